// ### design/slotio_consts.vh
// constants for the slot connector address and io block
`ifndef SLOTIO_CONSTS_VH
`define SLOTIO_CONSTS_VH
// apb register byte offsets
`define SLOTIO_CTRL_OFF      12'h000
`define SLOTIO_NVADDR_OFF    12'h004
`define SLOTIO_BAUD_OFF      12'h008
`define SLOTIO_STATUS_OFF    12'h00c
`define SLOTIO_INPUTS_OFF    12'h010
`define SLOTIO_ANALOG_OFF    12'h014
`define SLOTIO_ADDRSEL_OFF   12'h018
// control fields
`define SLOTIO_CTRL_LEFT_EN  0
`define SLOTIO_CTRL_RIGHT_EN 1
`define SLOTIO_CTRL_CANFW    2
`define SLOTIO_CTRL_AIN_DIG  3
`define SLOTIO_CTRL_DOUT0    4
`define SLOTIO_CTRL_RST      5'h00
// status fields
`define SLOTIO_ST_PINSRC     0
`define SLOTIO_ST_FACTORY    1
`define SLOTIO_ST_CANEN      2
`define SLOTIO_ST_BLKNEG     3
`define SLOTIO_ST_BLKPOS     4
// strap capture wait, edges after reset release minus one
`define SLOTIO_STRAP_WAIT    2'h3
// address values
`define SLOTIO_REPLY_PINS    8'hff
`define SLOTIO_NVADDR_RST    8'h01
// serial rate limits, bit/s
`define SLOTIO_BAUD_DEFAULT  32'd9600
`define SLOTIO_BAUD_MAX      32'd1000000
// analog full scale
`define SLOTIO_ADC_MAX       12'hfff
`endif

// ### design/slotio_top.v
// slot connector address select, limit gating and input sampling
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "slotio_consts.vh"

// What this block does
// - all pins low: use stored address
// - any pin high: pin value is address
// - pin address: reply address is 255
// - can firmware: node id from pins
// - left switch blocks negative steps
// - right switch blocks positive steps
// - analog result 12 bit, saturating
// - analog pin readable as digital
// - pad short at power-up restores defaults
// - restore needs no communication link
// - serial default 9600, never above 1M
// - usb present disables can
// - step and direction drive motor
// - accept three encoder channels
// - serial addressing up to 255 units
module slotio_top
(
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb register port
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // slot address straps, sampled once
   input  wire        slot_address_bit0,
   input  wire        slot_address_bit1,
   input  wire        slot_address_bit2,
   input  wire        slot_address_bit3,
   // limit switches, asynchronous
   input  wire        left_limit,
   input  wire        right_limit,
   // general inputs and analog pin
   input  wire        digital_input_0,
   input  wire        digital_input_1,
   input  wire        analog_input_dig,
   input  wire [12:0] analog_input_0,
   // incremental encoder channels
   input  wire        encoder_channel_a,
   input  wire        encoder_channel_b,
   input  wire        encoder_index,
   // step and direction from motion controller
   input  wire        step_in,
   input  wire        dir_in,
   // restore pads and usb detect
   input  wire        debug_clock_pad,
   input  wire        debug_data_pad,
   input  wire        usb_present,
   // gated motion outputs and link control
   output reg         step_out,
   output reg         dir_out,
   output reg         can_enable,
   output reg         factory_restore,
   // selected addresses and general output
   output reg  [7:0]  module_address,
   output reg  [7:0]  reply_address,
   output reg  [7:0]  can_node_id,
   output reg         digital_output_0
);

   // limits, general inputs, encoder, usb and both restore pads
   localparam NSYNC = 11;                  // synchronised input count

   // stage one and two of every async input
   // a level is used only once it has passed both stages, so a
   // pin that changes near the edge cannot split decisions
   wire [NSYNC-1:0] raw_in;                 // raw pins
   reg  [NSYNC-1:0] sync1_reg;              // first stage, read only by stage two
   reg  [NSYNC-1:0] sync2_reg;              // usable stage
   assign raw_in = {debug_data_pad, debug_clock_pad, usb_present, encoder_index,
                    encoder_channel_b, encoder_channel_a, analog_input_dig,
                    digital_input_1, digital_input_0, {left_limit, right_limit}};

   // synchroniser bank, one generate per bit
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1)
      begin : g_sync
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end
            else
            begin
               sync1_reg[gi] <= raw_in[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   // named synchronised levels
   wire right_s = sync2_reg[0];             // right limit
   wire left_s  = sync2_reg[1];             // left limit
   wire [2:0] gpi_s = sync2_reg[4:2];       // analog pin as digital, din1, din0
   wire [2:0] enc_s = sync2_reg[7:5];       // index, b, a
   wire usb_s   = sync2_reg[8];             // usb detect
   // both pads high together means the pads are shorted
   wire clkpad_s = sync2_reg[9];            // debug clock pad
   wire pads_s  = sync2_reg[10];            // debug data pad

   // software registers
   reg  [4:0]  ctrl_reg;                    // enables and modes
   reg  [7:0]  nvaddr_reg;                  // stored module address
   reg  [31:0] baud_reg;                    // serial bit rate
   reg  [11:0] adc_reg;                     // saturated analog code
   reg  [31:0] status_word;                 // status fields in place
   // strap capture
   reg         strap_done_reg;              // address pins taken
   reg  [3:0]  pins_reg;                    // captured pin value
   reg         restore_reg;                 // pad short seen at power-up
   reg  [1:0]  boot_cnt_reg;                // wait for synchronisers to fill

   // decoded levels used by several processes
   wire [3:0]  pins_now = {slot_address_bit3, slot_address_bit2,
                           slot_address_bit1, slot_address_bit0};
   wire        pin_src  = |pins_reg;
   wire        blk_neg  = ctrl_reg[`SLOTIO_CTRL_LEFT_EN] & left_s;
   wire        blk_pos  = ctrl_reg[`SLOTIO_CTRL_RIGHT_EN] & right_s;
   // a write lands in the access cycle, while ready stands
   wire        wr_en    = psel & penable & pwrite & pready;

   // one-shot capture of straps after reset release
   // the wait lets the pad synchronisers fill first, so the
   // restore decision never sees their reset value
   // the captured value then stands until the next reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_done_reg <= 1'b0;
         pins_reg       <= 4'h0;
         restore_reg    <= 1'b0;
         boot_cnt_reg   <= 2'h0;
      end
      else if (!strap_done_reg)
      begin
         // count edges since reset release
         boot_cnt_reg <= boot_cnt_reg + 2'h1;
         if (boot_cnt_reg == `SLOTIO_STRAP_WAIT)
         begin
            // capture straps and pad short together
            strap_done_reg <= 1'b1;
            pins_reg       <= pins_now;
            restore_reg    <= pads_s & clkpad_s;
         end
      end
   end

   // analog saturation at full scale
   // bit 12 flags an over-range sample from the converter
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         adc_reg <= 12'h000;
      else if (analog_input_0[12])
         adc_reg <= `SLOTIO_ADC_MAX;
      else
         adc_reg <= analog_input_0[11:0];
   end

   // software registers, restore reloads defaults
   // while the restore flag stands every write is dropped, so
   // the defaults survive until the pads are freed and reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg   <= `SLOTIO_CTRL_RST;
         nvaddr_reg <= `SLOTIO_NVADDR_RST;
         baud_reg   <= `SLOTIO_BAUD_DEFAULT;
      end
      else if (restore_reg)
      begin
         // restore holds every setting at its default
         ctrl_reg   <= `SLOTIO_CTRL_RST;
         nvaddr_reg <= `SLOTIO_NVADDR_RST;
         baud_reg   <= `SLOTIO_BAUD_DEFAULT;
      end
      else if (wr_en)
      begin
         // register write decode by byte offset
         case (paddr)
            `SLOTIO_CTRL_OFF:   ctrl_reg <= pwdata[4:0];
            `SLOTIO_NVADDR_OFF: nvaddr_reg <= pwdata[7:0];
            `SLOTIO_BAUD_OFF:
               // clamp to the top serial rate
               if (pwdata > `SLOTIO_BAUD_MAX)
                  baud_reg <= `SLOTIO_BAUD_MAX;
               else
                  baud_reg <= pwdata;
            default: ;
         endcase
      end
   end

   // address selection and outputs
   // the pin source is fixed at strap capture, so these only
   // follow the stored address when no strap pin was high
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_address   <= 8'h00;
         reply_address    <= 8'h00;
         can_node_id      <= 8'h00;
         can_enable       <= 1'b0;
         step_out         <= 1'b0;
         dir_out          <= 1'b0;
         factory_restore  <= 1'b0;
         digital_output_0 <= 1'b0;
      end
      else
      begin
         // strap mode against stored mode
         if (pin_src)
         begin
            module_address <= {4'h0, pins_reg};
            reply_address  <= `SLOTIO_REPLY_PINS;
            can_node_id    <= {4'h0, pins_reg};
         end
         else
         begin
            module_address <= nvaddr_reg;
            reply_address  <= nvaddr_reg;
            can_node_id    <= nvaddr_reg;
         end
         // can link is off whenever usb is attached
         can_enable <= ctrl_reg[`SLOTIO_CTRL_CANFW] & ~usb_s;
         // direction passes through one register
         dir_out    <= dir_in;
         // step suppressed toward a blocked side
         step_out   <= step_in & ~(dir_in ? blk_pos : blk_neg);
         // restore flag shown until the next reset
         factory_restore  <= restore_reg;
         digital_output_0 <= ctrl_reg[`SLOTIO_CTRL_DOUT0];
      end
   end

   // status word built from its field positions
   always @*
   begin
      status_word                      = 32'h0000_0000;
      status_word[`SLOTIO_ST_PINSRC]   = pin_src;
      status_word[`SLOTIO_ST_FACTORY]  = restore_reg;
      status_word[`SLOTIO_ST_CANEN]    = can_enable;
      status_word[`SLOTIO_ST_BLKNEG]   = blk_neg;
      status_word[`SLOTIO_ST_BLKPOS]   = blk_pos;
   end

   // apb slave, zero wait states
   // ready follows the setup cycle by one edge, and read data
   // is loaded on that same edge so it stands in the access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         // one wait-free answer per setup cycle
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         // read data taken from the setup cycle
         if (psel & ~penable)
         begin
            case (paddr)
               `SLOTIO_CTRL_OFF:   prdata <= {27'h0, ctrl_reg};
               `SLOTIO_NVADDR_OFF: prdata <= {24'h0, nvaddr_reg};
               `SLOTIO_BAUD_OFF:   prdata <= baud_reg;
               `SLOTIO_STATUS_OFF: prdata <= status_word;
               `SLOTIO_INPUTS_OFF: prdata <= {26'h0, enc_s, gpi_s};
               `SLOTIO_ANALOG_OFF: prdata <= {20'h0, adc_reg};
               `SLOTIO_ADDRSEL_OFF: prdata <= {8'h0, can_node_id, reply_address,
                                               module_address};
               // unmapped offset: error, zero data
               default:
               begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule

// ### tb/sias_asserts.sv
// checker for strap capture, limit gating and usb gating
`timescale 1ns/1ps
module sias_asserts
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        slot_address_bit0,
   input wire logic        slot_address_bit1,
   input wire logic        slot_address_bit2,
   input wire logic        slot_address_bit3,
   input wire logic        debug_clock_pad,
   input wire logic        debug_data_pad,
   input wire logic        left_limit,
   input wire logic        right_limit,
   input wire logic        dir_in,
   input wire logic        step_out,
   input wire logic        usb_present,
   input wire logic        can_enable,
   input wire logic        factory_restore,
   input wire logic [7:0]  module_address,
   input wire logic [7:0]  reply_address
);
   logic [2:0] cnt_reg;  // edges since reset release
   logic [3:0] pins_reg; // straps at the capture edge
   logic       pads_reg; // pad short at the capture edge
   logic [1:0] en_reg;   // limit enables as last written
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // count edges after release, saturating
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         cnt_reg <= 3'h0;
      else if (cnt_reg != 3'h7)
         cnt_reg <= cnt_reg + 3'h1;
   // mirror control writes, ignored during restore
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         en_reg <= 2'h0;
      else if (psel && penable && pready && pwrite && paddr == 12'h000 && !factory_restore)
         en_reg <= pwdata[1:0];
   // copy straps at the fourth edge
   always @(posedge pclk)
      if (cnt_reg == 3'h3)
      begin
         pins_reg <= {slot_address_bit3, slot_address_bit2, slot_address_bit1, slot_address_bit0};
         pads_reg <= debug_clock_pad && debug_data_pad;
      end
   AST_PREADY: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_PIN_ADDR: assert property (cnt_reg >= 3'h5 && pins_reg != 4'h0 |->
      module_address == {4'h0, pins_reg} && reply_address == 8'hff) else $error("pin address");
   AST_STORED: assert property (cnt_reg >= 3'h5 && pins_reg == 4'h0 |->
      reply_address == module_address) else $error("stored address reply");
   AST_HOLD: assert property (cnt_reg == 3'h7 && pins_reg != 4'h0 |->
      $stable(module_address) && $stable(reply_address)) else $error("address moved");
   AST_RESTORE: assert property (cnt_reg >= 3'h5 |-> factory_restore == pads_reg)
      else $error("restore flag");
   AST_LEFT: assert property ((en_reg[0] && left_limit && !dir_in)[*4] |=> !step_out)
      else $error("step passed left limit");
   AST_RIGHT: assert property ((en_reg[1] && right_limit && dir_in)[*4] |=> !step_out)
      else $error("step passed right limit");
   AST_USB: assert property (usb_present[*4] |=> !can_enable)
      else $error("can on with usb");
endmodule
bind slotio_top sias_asserts u_chk (.*);

// ### tb/sias_stepgen.sv
// step and direction source for an external motion controller
`timescale 1ns/1ps
module sias_stepgen
(
   input  wire logic pclk,
   output logic      step_in,
   output logic      dir_in
);
   integer seed = 32'h57569f5d; // fixed seed
   initial
   begin
      step_in = 1'b0;
      dir_in  = 1'b0;
   end
   // square step pulses, direction turns rarely
   always @(posedge pclk)
   begin
      step_in <= ~step_in;
      if ($random(seed) % 32 == 0)
         dir_in <= ~dir_in;
   end
endmodule

// ### tb/slot_io_address_select_tb.sv
// testbench for the slot address select and io block
`timescale 1ns/1ps
`include "slotio_consts.vh"
module slot_io_address_select_tb;
   logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q, v;
   logic slot_address_bit0 = 0, slot_address_bit1 = 0, slot_address_bit2 = 0;
   logic slot_address_bit3 = 0, left_limit = 0, right_limit = 0, usb_present = 0;
   logic digital_input_0 = 0, digital_input_1 = 0, analog_input_dig = 0, step_in, dir_in;
   logic encoder_channel_a = 0, encoder_channel_b = 0, encoder_index = 0;
   logic debug_clock_pad = 0, debug_data_pad = 0, step_out, dir_out, can_enable;
   logic factory_restore, digital_output_0;
   logic [12:0] analog_input_0 = 0;
   logic [7:0] module_address, reply_address, can_node_id;
   logic [3:0] p;
   integer seed = 32'h57569f5d, err_count = 0, n_compared = 0, i;
   slotio_top u_dut (.*);
   sias_stepgen u_src (.pclk(pclk), .step_in(step_in), .dir_in(dir_in));
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // expected converter reading, saturating
   function logic [31:0] f_adc(input logic [12:0] a);
      f_adc = a[12] ? {20'h0, `SLOTIO_ADC_MAX} : {20'h0, a[11:0]};
   endfunction
   // expected rate after a write, clamped
   function logic [31:0] f_baud(input logic [31:0] d);
      f_baud = (d > `SLOTIO_BAUD_MAX) ? `SLOTIO_BAUD_MAX : d;
   endfunction
   // expected step output with both limit gates enabled
   function logic f_step(input logic s, input logic d, input logic l, input logic r);
      f_step = s & ~(d ? r : l);
   endfunction
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x)
      begin
         $display("wrong value %s exp %h got %h", s, x, g);
         err_count++;
      end
   endtask
   // one apb transfer, bounded wait for ready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do
            @(posedge pclk);
         while (pready !== 1'b1 && n++ < 20);
         if (n >= 20)
         begin
            err_count++;
            conclude;
         end
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("register", x, q);
   endtask
   // reset with given straps, wait until addresses settle
   task do_rst(input logic [3:0] ps, input logic [1:0] d);
      {slot_address_bit3, slot_address_bit2, slot_address_bit1, slot_address_bit0} <= ps;
      {debug_clock_pad, debug_data_pad} <= d;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
   initial
   begin
      repeat (60000) @(posedge pclk);
      err_count++;
      conclude;
   end
   initial
   begin
      do_rst(4'h0, 2'b00);
      chk("module address", 32'h01, module_address);
      rd(`SLOTIO_BAUD_OFF, `SLOTIO_BAUD_DEFAULT);
      apb(1'b1, `SLOTIO_BAUD_OFF, 32'hffffffff);
      rd(`SLOTIO_BAUD_OFF, f_baud(32'hffffffff));
      v = $random(seed);
      apb(1'b1, `SLOTIO_NVADDR_OFF, {24'h0, v[7:0]});
      rd(`SLOTIO_NVADDR_OFF, {24'h0, v[7:0]});
      apb(1'b0, 12'h01c, 32'h0);
      chk("slave error", 32'h1, e);
      for (i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 32'h1000 : (i == 1) ? 32'h0fff : $random(seed);
         analog_input_0 <= v[12:0];
         repeat (3) @(posedge pclk);
         rd(`SLOTIO_ANALOG_OFF, f_adc(v[12:0]));
      end
      $display("stored address and converter test done");
      apb(1'b1, `SLOTIO_CTRL_OFF, 32'h1b);
      repeat (2) @(posedge pclk);
      chk("digital output", 32'h1, digital_output_0);
      for (i = 0; i < 30; i++)
      begin
         v = $random(seed);
         {encoder_index, encoder_channel_b, encoder_channel_a} <= v[5:3];
         {analog_input_dig, digital_input_1, digital_input_0} <= v[2:0];
         {left_limit, right_limit} <= v[7:6];
         repeat (12) @(posedge pclk);
         rd(`SLOTIO_INPUTS_OFF, {26'h0, v[5:0]});
         @(posedge pclk);
         p[1:0] = {step_in, dir_in};
         @(posedge pclk);
         chk("dir out", p[0], dir_out);
         chk("step out", f_step(p[1], p[0], left_limit, right_limit), step_out);
      end
      $display("input and limit test done");
      apb(1'b1, `SLOTIO_CTRL_OFF, 32'h4);
      repeat (4) @(posedge pclk);
      chk("can enable", 32'h1, can_enable);
      usb_present <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("can enable", 32'h0, can_enable);
      usb_present <= 1'b0;
      for (i = 0; i < 3; i++)
      begin
         v = $random(seed);
         p = (i == 0) ? 4'h1 : (i == 1) ? 4'hf : (v[3:0] | 4'h8);
         do_rst(p, 2'b00);
         apb(1'b1, `SLOTIO_CTRL_OFF, 32'h4);
         repeat (2) @(posedge pclk);
         rd(`SLOTIO_ADDRSEL_OFF, {8'h0, 4'h0, p, 8'hff, 4'h0, p});
      end
      $display("pin address test done");
      do_rst(4'h0, 2'b11);
      chk("restore", 32'h1, factory_restore);
      apb(1'b1, `SLOTIO_BAUD_OFF, 32'h1234);
      rd(`SLOTIO_BAUD_OFF, `SLOTIO_BAUD_DEFAULT);
      apb(1'b1, `SLOTIO_CTRL_OFF, 32'h10);
      repeat (2) @(posedge pclk);
      chk("digital output", 32'h0, digital_output_0);
      rd(`SLOTIO_STATUS_OFF, 32'h1 << `SLOTIO_ST_FACTORY);
      $display("restore test done");
      conclude;
   end
endmodule
